/* ifd_core.sv */
`timescale 1ns/1ns
`default_nettype none
module ifd_core (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // instruction fetch
    input wire logic [ifd_pkg::WORD_W-1:0] insnWord,
    output logic fetchStrobe,
    // execute feedback
    input wire logic condTrue,
    input wire logic [ifd_pkg::DATA_W-1:0] regReadData,
    input wire logic [ifd_pkg::DATA_W-1:0] aluResult,
    // decoded instruction
    output logic [1:0] category,
    output logic [ifd_pkg::FADDR_W-1:0] regAddr,
    output logic destToReg,
    output logic [ifd_pkg::BITPOS_W-1:0] bitPos,
    output logic [ifd_pkg::DATA_W-1:0] bitMask,
    output logic [ifd_pkg::LIT8_W-1:0] lit8,
    output logic [ifd_pkg::LIT11_W-1:0] lit11,
    output logic flushCycle,
    // register file and accumulator access
    output logic regRead,
    output logic regWrite,
    output logic accWrite,
    output logic [ifd_pkg::DATA_W-1:0] writeData,
    output logic [ifd_pkg::DATA_W-1:0] latchedRead
);
    import ifd_pkg::*;

    typedef struct packed {
        logic [PH_W-1:0] phase;
        ifd_mode_t mode;
        logic [WORD_W-1:0] word;
        logic [DATA_W-1:0] rdData;
        logic fetch;
        logic rd;
        logic wrReg;
        logic wrAcc;
        logic [DATA_W-1:0] wdata;
    } ifd_state_t;

    ifd_state_t st;
    ifd_state_t next_st;

    // one-hot mask for a bit position, used only by the bitMask output
    function automatic logic [DATA_W-1:0] bit_onehot(
        input logic [BITPOS_W-1:0] pos
    );
        bit_onehot = 8'h01 << pos;
    endfunction : bit_onehot

    logic [1:0] cat;
    logic [3:0] subOp;
    logic hasReg;
    logic toReg;
    logic endsFlow;
    logic condInsn;
    // taken branch or true skip: the next fetched word is dropped
    logic flushCause;

    always_comb begin
        cat = st.word[CAT_MSB:CAT_LSB];
        subOp = st.word[SUBOP_MSB:SUBOP_LSB];
        hasReg = 1'b0;
        toReg = 1'b0;
        endsFlow = 1'b0;
        condInsn = 1'b0;
        case (cat)
            CAT_BYTE: begin
                // misc group holds word-only ops; bit 7 marks register move
                if (subOp == SUB_MISC) begin
                    hasReg = st.word[DEST_POS];
                    toReg = st.word[DEST_POS];
                    endsFlow = (st.word[7:0] == MISC_RETURN)
                        || (st.word[7:0] == MISC_RETFIE);
                end else if (subOp == SUB_CLR) begin
                    hasReg = st.word[DEST_POS];
                    toReg = st.word[DEST_POS];
                end else begin
                    hasReg = 1'b1;
                    toReg = st.word[DEST_POS];
                end
                condInsn = (subOp == SUB_DECSZ) || (subOp == SUB_INCSZ);
            end
            CAT_BIT: begin
                hasReg = 1'b1;
                toReg = !st.word[SUBOP_MSB];
                condInsn = st.word[SUBOP_MSB];
            end
            CAT_JUMP: begin
                endsFlow = 1'b1;
            end
            CAT_LIT: begin
                // ignores don't-care bits of movlw/retlw/addlw/sublw
                endsFlow = (st.word[SUBOP_MSB:10] == LIT_RETLW);
            end
            default: begin
                hasReg = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.fetch = 1'b0;
        next_st.rd = 1'b0;
        next_st.wrReg = 1'b0;
        next_st.wrAcc = 1'b0;
        next_st.phase = st.phase + 2'h1;
        if (st.phase == PH_LAST) begin
            next_st.fetch = 1'b1;
            // a flushed cycle drops the prefetched word
            if (st.mode == IFD_NORMAL && flushCause) begin
                next_st.mode = IFD_FLUSH;
                next_st.word = NOP_WORD;
            end else begin
                next_st.mode = IFD_NORMAL;
                next_st.word = insnWord;
            end
        end
        if (st.mode == IFD_NORMAL && hasReg) begin
            // read always precedes the write, also for clear ops
            if (st.phase == 2'h1) begin
                next_st.rd = 1'b1;
            end
            if (st.phase == 2'h2) begin
                next_st.rdData = regReadData;
            end
        end
        if (st.mode == IFD_NORMAL && st.phase == 2'h2) begin
            next_st.wdata = aluResult;
            // port rewrite here is what clears its change mismatch
            next_st.wrReg = hasReg && toReg;
            // skip-if-zero ops with d=0 still put their result in W
            next_st.wrAcc = !toReg && cat != CAT_JUMP
                && cat != CAT_BIT;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{phase: PH_RESET, mode: IFD_FLUSH, word: NOP_WORD,
                    rdData: 8'h00, fetch: 1'b0, rd: 1'b0, wrReg: 1'b0,
                    wrAcc: 1'b0, wdata: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign flushCause = endsFlow || (condInsn && condTrue);
    assign fetchStrobe = st.fetch;
    assign category = cat;
    assign regAddr = st.word[FADDR_W-1:0];
    assign destToReg = toReg;
    assign bitPos = st.word[BITPOS_LSB+BITPOS_W-1:BITPOS_LSB];
    assign bitMask = bit_onehot(bitPos);
    assign lit8 = st.word[LIT8_W-1:0];
    assign lit11 = st.word[LIT11_W-1:0];
    assign flushCycle = (st.mode == IFD_FLUSH);
    assign regRead = st.rd;
    assign regWrite = st.wrReg;
    assign accWrite = st.wrAcc;
    assign writeData = st.wdata;
    assign latchedRead = st.rdData;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence rd_seq;
        regRead ##1 1'b1;
    endsequence
    sequence wr_seq;
        regWrite;
    endsequence
    sequence flush_hold;
        flushCycle [*4] ##1 !flushCycle;
    endsequence

    fetch_period_a: assert property (
        fetchStrobe |=> !fetchStrobe [*3] ##1 fetchStrobe)
        else $error("fetch strobe not every four clocks");
    read_first_a: assert property (
        wr_seq |-> $past(regRead))
        else $error("register write without prior read");
    read_then_a: assert property (
        rd_seq |-> regWrite == destToReg
            && accWrite == (!destToReg && category == CAT_BYTE))
        else $error("read not followed by store");
    dest_acc_a: assert property (accWrite |-> !regWrite)
        else $error("both destinations written");
    flush_len_a: assert property ($rose(flushCycle) |-> flush_hold)
        else $error("flush cycle not one instruction cycle");
    flush_quiet_a: assert property (
        flushCycle |-> !regRead && !regWrite && !accWrite)
        else $error("flush cycle touched registers");
    mask_onehot_a: assert property (
        $onehot(bitMask) && bitMask[bitPos])
        else $error("bit mask not one-hot");
    addr_stable_a: assert property (
        !fetchStrobe |-> $stable(regAddr))
        else $error("register address moved within a cycle");
    flush_cause_a: assert property (
        $rose(flushCycle) |-> fetchStrobe && $past(flushCause))
        else $error("flush without cause");
    skip_flush_a: assert property (
        fetchStrobe && !$past(flushCycle) && $past(flushCause)
            |-> flushCycle)
        else $error("taken branch or skip not flushed");
    fetch_word_a: assert property (
        fetchStrobe && !flushCycle |-> st.word == $past(insnWord))
        else $error("fetched word not the offered one");
    bit_no_acc_a: assert property (
        category == CAT_BIT |-> !accWrite)
        else $error("bit operation wrote the accumulator");
    lit_no_reg_a: assert property (
        regWrite |-> category == CAT_BYTE || category == CAT_BIT)
        else $error("literal or jump wrote a register");
endmodule : ifd_core
`default_nettype wire

/* ifd_pkg.sv */
package ifd_pkg;
    localparam int WORD_W = 14;
    localparam int FADDR_W = 7;
    localparam int BITPOS_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int DATA_W = 8;
    // field positions inside the instruction word
    localparam int CAT_MSB = 13;
    localparam int CAT_LSB = 12;
    localparam int DEST_POS = 7;
    localparam int BITPOS_LSB = 7;
    localparam int SUBOP_MSB = 11;
    localparam int SUBOP_LSB = 8;
    // categories from the two top bits
    localparam logic [1:0] CAT_BYTE = 2'h0;
    localparam logic [1:0] CAT_BIT = 2'h1;
    localparam logic [1:0] CAT_JUMP = 2'h2;
    localparam logic [1:0] CAT_LIT = 2'h3;
    // sub-opcodes; the decoder uses all but BIT_TSTC and BIT_TSTS
    localparam logic [3:0] SUB_MISC = 4'h0;
    localparam logic [3:0] SUB_CLR = 4'h1;
    localparam logic [3:0] SUB_DECSZ = 4'hb;
    localparam logic [3:0] SUB_INCSZ = 4'hf;
    localparam logic [1:0] BIT_TSTC = 2'h2;
    localparam logic [1:0] BIT_TSTS = 2'h3;
    localparam logic [1:0] LIT_RETLW = 2'h1;
    localparam logic [7:0] MISC_RETURN = 8'h08;
    localparam logic [7:0] MISC_RETFIE = 8'h09;
    // timing
    localparam int OSC_PER_CYCLE = 4;
    localparam int PH_W = 2;
    localparam logic [PH_W-1:0] PH_RESET = 2'h0;
    localparam logic [PH_W-1:0] PH_LAST = 2'h3;
    localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;
    typedef enum logic [1:0] {
        IFD_NORMAL = 2'b00,
        IFD_FLUSH = 2'b01
    } ifd_mode_t;
endpackage : ifd_pkg

/* test_insn_format_decode_core.sv */
`timescale 1ns/1ns
`default_nettype none
module test_insn_format_decode_core;
    import ifd_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [WORD_W-1:0] insnWord = NOP_WORD;
    logic condTrue = 1'b0;
    logic [DATA_W-1:0] regReadData = 8'h00;
    logic [DATA_W-1:0] aluResult = 8'h00;
    logic fetchStrobe, destToReg, flushCycle, regRead, regWrite, accWrite;
    logic [1:0] category;
    logic [FADDR_W-1:0] regAddr;
    logic [BITPOS_W-1:0] bitPos;
    logic [DATA_W-1:0] bitMask, writeData, latchedRead, lit8;
    logic [LIT11_W-1:0] lit11;
    logic [WORD_W-1:0] cur = NOP_WORD;
    logic curFlush = 1'b0;
    int fails = 0;
    int samples_checked = 0;
    // cond bit on top of each hand-picked word: branches, skips, edges
    localparam logic [14:0] CORNER [18] = '{15'h2abc, 15'h2123, 15'h0008,
        15'h0009, 15'h3455, 15'h4bff, 15'h0f80, 15'h5f80, 15'h1800,
        15'h0185, 15'h0100, 15'h1385, 15'h1005, 15'h3aff, 15'h3e01,
        15'h3f01, 15'h3300, 15'h0701};
    always #5 mclk = ~mclk;
    ifd_core uut (.mclk(mclk), .rst_n(rst_n), .insnWord(insnWord),
        .fetchStrobe(fetchStrobe), .condTrue(condTrue),
        .regReadData(regReadData), .aluResult(aluResult),
        .category(category), .regAddr(regAddr), .destToReg(destToReg),
        .bitPos(bitPos), .bitMask(bitMask), .lit8(lit8), .lit11(lit11),
        .flushCycle(flushCycle), .regRead(regRead), .regWrite(regWrite),
        .accWrite(accWrite), .writeData(writeData),
        .latchedRead(latchedRead));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask : check
    task automatic report_and_stop;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    function automatic logic flushNext(input logic [WORD_W-1:0] w,
            input logic c);
        case (w[13:12])
            CAT_JUMP: return 1'b1;
            CAT_LIT: return w[11:10] == LIT_RETLW;
            CAT_BIT: return w[11] && c;
            default: return ((w[11:8] == SUB_DECSZ || w[11:8] == SUB_INCSZ)
                && c) || (w[11:8] == SUB_MISC && (w[7:0] == MISC_RETURN
                || w[7:0] == MISC_RETFIE));
        endcase
    endfunction : flushNext
    task automatic step(input logic [WORD_W-1:0] nxt, input logic c);
        logic [DATA_W-1:0] alu, rd;
        logic act, eReg, eAcc;
        alu = 8'($urandom);
        rd = 8'($urandom);
        // clear/misc words read a register only when bit 7 is set
        act = !curFlush && (cur[13:12] == CAT_BIT
            || (cur[13:12] == CAT_BYTE && (cur[11:9] != 3'h0 || cur[7])));
        eReg = !curFlush && ((cur[13:12] == CAT_BYTE && cur[7])
            || (cur[13:12] == CAT_BIT && !cur[11]));
        eAcc = !curFlush && ((cur[13:12] == CAT_BYTE && !cur[7])
            || cur[13:12] == CAT_LIT);
        insnWord <= nxt;
        condTrue <= c;
        aluResult <= alu;
        regReadData <= rd;
        @(negedge mclk);
        check(fetchStrobe, 1'b1);
        check(flushCycle, curFlush);
        check(category, cur[13:12]);
        if (cur[13:12] < 2'h2) check(regAddr, cur[6:0]);
        if (cur[13:12] == CAT_BYTE) check(destToReg, cur[7]);
        if (cur[13:12] == CAT_BIT) begin
            check(bitPos, cur[9:7]);
            check(bitMask, 8'h01 << cur[9:7]);
            check(destToReg, !cur[11]);
        end
        if (cur[13:12] == CAT_LIT) check(lit8, cur[7:0]);
        if (cur[13:12] == CAT_JUMP) check(lit11, cur[10:0]);
        repeat (2) @(negedge mclk);
        check(regRead, act);
        @(negedge mclk);
        check(regWrite, eReg);
        check(accWrite, eAcc);
        if (act) check(latchedRead, rd);
        if (eReg || eAcc) check(writeData, alu);
        @(posedge mclk);
        curFlush = !curFlush && flushNext(cur, c);
        cur = curFlush ? NOP_WORD : nxt;
    endtask : step
    initial begin
        int n;
        void'($urandom(99026));
        repeat (10) @(posedge mclk);
        check(fetchStrobe, 1'b0);
        check(flushCycle, 1'b1);
        rst_n <= 1'b1;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (fetchStrobe !== 1'b1 && n < 10);
        check(16'(n), 16'h0005);
        repeat (4) @(posedge mclk);
        foreach (CORNER[i]) step(CORNER[i][13:0], CORNER[i][14]);
        repeat (200) step(14'($urandom), 1'($urandom));
        report_and_stop();
    end
    // whole run is about ten microseconds; ten times that means a hang
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
endmodule : test_insn_format_decode_core
`default_nettype wire
